// ### verilog/mme_exec.sv
// Notes on behaviour
// - Register copy move, two cycles
// - Program memory load, post-increment, eight cycles
// - Program memory store, post-increment addressing
// - Conditional transfer into accumulator, restricted conditions
// - Transfer variant also copies address zero to one
// - Integer 16x16 multiply, six pairs, two cycles
// - Integer multiply keeps accumulator low word
// - Multiply-accumulate with optional product negation
// - Rounding multiply-accumulate
// - Fractional multiply, optional operand negation
// - Rounding fractional multiply
// - Accumulators are 36 bits wide
`default_nettype none
module mme_exec
(
  input  wire logic                 clk,        // Core clock
  input  wire logic                 reset_n,    // Sync reset, active low
  input  wire logic                 start,      // Issue pulse
  input  wire mme_pkg::mme_op_t     op,         // Instruction class
  input  wire mme_pkg::mme_reg_t    src,        // Source register
  input  wire mme_pkg::mme_reg_t    dst,        // Destination register
  input  wire mme_pkg::mme_pair_t   pair,       // Multiplier operands
  input  wire mme_pkg::mme_mdst_t   mdst,       // Multiply destination
  input  wire logic                 negate,     // Negate product
  input  wire logic [1:0]           areg,       // Address register index
  input  wire logic                 post_n,     // Step by offset, not one
  input  wire mme_pkg::mme_cond_t   cond_code,  // Transfer condition
  input  wire logic                 cond_met,   // Condition holds
  input  wire logic                 agu_copy,   // Also copy address 0 to 1
  input  wire logic                 data_memory_execution_bit, // Mode bit
  input  wire logic [15:0]          pm_rdata,   // Program memory read data
  output logic      [15:0]          pm_addr,    // Program memory address
  output logic      [15:0]          pm_wdata,   // Program memory write data
  output logic                      pm_rd_en,   // Read in progress
  output logic                      pm_wr_en,   // Write strobe
  output logic                      busy,       // Instruction in flight
  output logic                      done,       // Last cycle, commit
  output logic                      illegal,    // Issue refused
  output logic      [15:0]          x0,         // Data register X0
  output logic      [15:0]          y0,         // Data register Y0
  output logic      [15:0]          y1,         // Data register Y1
  output logic      [35:0]          acc_a,      // Accumulator A
  output logic      [35:0]          acc_b,      // Accumulator B
  output logic      [15:0]          addr_reg [4], // Address registers
  output logic      [15:0]          offset_n    // Offset register
);
  import mme_pkg::*;

  mme_state_t state;          // Sequencer state
  mme_state_t next_state;     // Next sequencer state
  logic [3:0] cnt;            // Cycles left
  mme_op_t    op_q;           // Latched instruction fields
  mme_reg_t   src_q;
  mme_reg_t   dst_q;
  mme_pair_t  pair_q;
  mme_mdst_t  mdst_q;
  logic       neg_q;
  logic [1:0] areg_q;
  logic       postn_q;
  logic       cmet_q;
  logic       agu_q;
  logic [15:0] next_x0;       // Next register values
  logic [15:0] next_y0;
  logic [15:0] next_y1;
  logic [35:0] next_acc_a;
  logic [35:0] next_acc_b;
  logic [15:0] next_addr [4];
  logic [15:0] next_offset;
  logic [15:0] word_view [16]; // Word view of the general register set
  logic [15:0] src_word;       // Selected source word (latched fields)
  logic [15:0] issue_word;     // Selected source word (issue fields)
  logic [35:0] x0_acc_form;    // X0 as accumulator image
  // Issue decode
  wire is_pm      = (op == OP_PM_LOAD) || (op == OP_PM_STORE);
  wire is_mul     = (op >= OP_INTEGER_MULTIPLY) &&
                    (op <= OP_ROUNDING_FRAC_MUL);
  wire src_is_acc = (src == REG_ACCA) || (src == REG_ACCB);
  wire dst_is_acc = (dst == REG_ACCA) || (dst == REG_ACCB);
  wire cond_bad   = (cond_code >= COND_UNSIGNED_GREATER);
  wire tcc_bad    = cond_bad || !dst_is_acc ||
                    (src_is_acc ? (src == dst) : (src > REG_Y1));
  wire mul_bad    = (pair > PAIR_B1_Y1) || (mdst > MDST_Y1);
  wire refuse     = (is_pm && data_memory_execution_bit) ||
                    ((op == OP_COND_TRANSFER) && tcc_bad) ||
                    (is_mul && mul_bad) || (op > OP_ROUNDING_FRAC_MUL);
  wire idle       = (state == ST_IDLE);
  wire take       = start && idle && !refuse;
  wire commit     = !idle && (cnt == 4'h1);
  // Cycle count per class
  wire [3:0] cyc_sel = is_pm ? CYC_PMEM :
                       (op == OP_COND_TRANSFER) ? CYC_TCC :
                       is_mul ? CYC_MUL : CYC_MOVE;
  // Handshake outputs
  assign busy     = !idle;
  assign done     = commit;
  assign illegal  = start && idle && refuse;
  assign pm_rd_en = (state == ST_PMEM) && (op_q == OP_PM_LOAD);
  assign pm_wr_en = commit && (op_q == OP_PM_STORE);
  // Word view: a whole accumulator reads as its high word
  assign word_view[REG_X0]        = x0;
  assign word_view[REG_Y0]        = y0;
  assign word_view[REG_Y1]        = y1;
  assign word_view[REG_ACCA_LOW]  = acc_a[15:0];
  assign word_view[REG_ACCA_HIGH] = acc_a[31:16];
  assign word_view[REG_ACCA_EXT]  = {{12{acc_a[35]}}, acc_a[35:32]};
  assign word_view[REG_ACCB_LOW]  = acc_b[15:0];
  assign word_view[REG_ACCB_HIGH] = acc_b[31:16];
  assign word_view[REG_ACCB_EXT]  = {{12{acc_b[35]}}, acc_b[35:32]};
  assign word_view[REG_ACCA]      = acc_a[31:16];
  assign word_view[REG_ACCB]      = acc_b[31:16];
  assign word_view[REG_ADDR0]     = addr_reg[0];
  assign word_view[REG_ADDR1]     = addr_reg[1];
  assign word_view[REG_ADDR2]     = addr_reg[2];
  assign word_view[REG_ADDR3]     = addr_reg[3];
  assign word_view[REG_OFFSET]    = offset_n;
  assign src_word    = word_view[src_q];
  assign issue_word  = word_view[src];
  assign x0_acc_form = {{4{x0[15]}}, x0, 16'h0000};
  // Multiplier operand selection
  wire [15:0] mul_a = (pair_q == PAIR_Y1_X0 || pair_q == PAIR_Y1_Y0) ? y1 :
                      (pair_q == PAIR_A1_Y0) ? acc_a[31:16] :
                      (pair_q == PAIR_B1_Y1) ? acc_b[31:16] : y0;
  wire [15:0] mul_b = (pair_q == PAIR_Y1_X0 || pair_q == PAIR_Y0_X0) ? x0 :
                      (pair_q == PAIR_B1_Y1) ? y1 : y0;
  wire        mdst_acc  = (mdst_q == MDST_ACCA) || (mdst_q == MDST_ACCB);
  wire [15:0] mdst_word = (mdst_q == MDST_X0) ? x0 :
                          (mdst_q == MDST_Y0) ? y0 : y1;
  wire [35:0] mul_acc_in = (mdst_q == MDST_ACCA) ? acc_a :
                           (mdst_q == MDST_ACCB) ? acc_b :
                           {{4{mdst_word[15]}}, mdst_word, 16'h0000};
  wire op_is_int  = (op_q == OP_INTEGER_MULTIPLY);
  wire op_accum   = (op_q == OP_MULTIPLY_ACCUMULATE) ||
                    (op_q == OP_ROUNDING_MAC);
  wire op_round   = (op_q == OP_ROUNDING_MAC) ||
                    (op_q == OP_ROUNDING_FRAC_MUL);
  wire [35:0] mul_frac;
  wire [15:0] mul_int;
  // Shared multiplier
  mme_mul_unit u_mul
  (
    .op_a        (mul_a),
    .op_b        (mul_b),
    .negate      (neg_q && !op_is_int),
    .accumulate  (op_accum),
    .round_en    (op_round),
    .acc_in      (mul_acc_in),
    .frac_result (mul_frac),
    .int_result  (mul_int)
  );
  // Integer result into an accumulator keeps its low word
  wire [35:0] int_acc_cur = (mdst_q == MDST_ACCA) ? acc_a : acc_b;
  wire [35:0] int_acc_val = {{4{mul_int[15]}}, mul_int, int_acc_cur[15:0]};
  wire [35:0] mul_acc_val = op_is_int ? int_acc_val : mul_frac;
  wire [15:0] mul_word    = op_is_int ? mul_int : mul_frac[31:16];
  // Conditional transfer value into an accumulator
  wire [35:0] tcc_val = (src_q == REG_ACCA) ? acc_a :
                        (src_q == REG_ACCB) ? acc_b :
                        {{4{src_word[15]}}, src_word, 16'h0000};
  wire tcc_go = commit && (op_q == OP_COND_TRANSFER) && cmet_q;
  // Word write port
  wire wr_mul_word = commit && (op_q >= OP_INTEGER_MULTIPLY) && !mdst_acc;
  wire wr_word = (commit && ((op_q == OP_REGISTER_COPY_MOVE) ||
                             (op_q == OP_PM_LOAD))) || wr_mul_word;
  wire [3:0] wr_idx = !wr_mul_word ? dst_q :
                      (mdst_q == MDST_X0) ? REG_X0 :
                      (mdst_q == MDST_Y0) ? REG_Y0 : REG_Y1;
  wire [15:0] wr_data = (op_q == OP_REGISTER_COPY_MOVE) ? src_word :
                        (op_q == OP_PM_LOAD) ? pm_rdata :
                        mul_word;
  wire [35:0] wr_acc_form = {{4{wr_data[15]}}, wr_data, 16'h0000};
  wire [15:0] pm_step = postn_q ? offset_n : 16'h0001;

  // Next register values; later writes take precedence
  always_comb
  begin
    next_x0     = x0;
    next_y0     = y0;
    next_y1     = y1;
    next_acc_a  = acc_a;
    next_acc_b  = acc_b;
    next_addr   = addr_reg;
    next_offset = offset_n;
    // Post-increment of the address register
    if (commit && ((op_q == OP_PM_LOAD) || (op_q == OP_PM_STORE)))
    begin
      next_addr[areg_q] = 16'(addr_reg[areg_q] + pm_step);
    end
    // Address zero to one beside the data transfer
    if (tcc_go && agu_q)
    begin
      next_addr[1] = addr_reg[0];
    end
    // Word write into the general register set
    if (wr_word)
    begin
      case (wr_idx)
        REG_X0:        next_x0 = wr_data;
        REG_Y0:        next_y0 = wr_data;
        REG_Y1:        next_y1 = wr_data;
        REG_ACCA_LOW:  next_acc_a[15:0] = wr_data;
        REG_ACCA_HIGH: next_acc_a[31:16] = wr_data;
        REG_ACCA_EXT:  next_acc_a[35:32] = wr_data[3:0];
        REG_ACCB_LOW:  next_acc_b[15:0] = wr_data;
        REG_ACCB_HIGH: next_acc_b[31:16] = wr_data;
        REG_ACCB_EXT:  next_acc_b[35:32] = wr_data[3:0];
        REG_ACCA:      next_acc_a = wr_acc_form;
        REG_ACCB:      next_acc_b = wr_acc_form;
        REG_ADDR0:     next_addr[0] = wr_data;
        REG_ADDR1:     next_addr[1] = wr_data;
        REG_ADDR2:     next_addr[2] = wr_data;
        REG_ADDR3:     next_addr[3] = wr_data;
        default:       next_offset = wr_data;
      endcase
    end
    // Whole accumulator writes
    if (tcc_go)
    begin
      if (dst_q == REG_ACCA) next_acc_a = tcc_val;
      else                   next_acc_b = tcc_val;
    end
    if (commit && (op_q >= OP_INTEGER_MULTIPLY) && mdst_acc)
    begin
      if (mdst_q == MDST_ACCA) next_acc_a = mul_acc_val;
      else                     next_acc_b = mul_acc_val;
    end
  end

  // Sequencer next state
  always_comb
  begin
    case (state)
      ST_IDLE: next_state = !take ? ST_IDLE : is_pm ? ST_PMEM : ST_EXEC;
      ST_EXEC: next_state = commit ? ST_IDLE : ST_EXEC;
      ST_PMEM: next_state = commit ? ST_IDLE : ST_PMEM;
      default: next_state = ST_IDLE;
    endcase
  end

  // Sequencer and cycle counter
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state <= ST_IDLE;
      cnt   <= 4'h0;
    end
    else
    begin
      state <= next_state;
      cnt   <= take ? 4'(cyc_sel - 4'h1) : (idle ? 4'h0 : 4'(cnt - 4'h1));
    end
  end

  // Latch instruction fields and memory address at issue
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      op_q <= OP_REGISTER_COPY_MOVE;  src_q  <= REG_X0;  dst_q <= REG_X0;
      pair_q <= PAIR_Y1_X0;  mdst_q <= MDST_ACCA;  neg_q <= 1'b0;
      areg_q <= 2'h0;  postn_q <= 1'b0;  cmet_q <= 1'b0;  agu_q <= 1'b0;
      pm_addr <= RST_WORD;  pm_wdata <= RST_WORD;
    end
    else if (take)
    begin
      op_q <= op;  src_q <= src;  dst_q <= dst;
      pair_q <= pair;  mdst_q <= mdst;  neg_q <= negate;
      areg_q <= areg;  postn_q <= post_n;  cmet_q <= cond_met;
      agu_q <= agu_copy;
      pm_addr <= addr_reg[areg];  pm_wdata <= issue_word;
    end
  end

  // Register file
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      x0 <= RST_WORD;  y0 <= RST_WORD;  y1 <= RST_WORD;
      acc_a <= RST_ACC;  acc_b <= RST_ACC;
      addr_reg <= '{default: RST_WORD};  offset_n <= RST_WORD;
    end
    else
    begin
      x0 <= next_x0;  y0 <= next_y0;  y1 <= next_y1;
      acc_a <= next_acc_a;  acc_b <= next_acc_b;
      addr_reg <= next_addr;  offset_n <= next_offset;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_move_two_cycles: assert property (
    take && op == OP_REGISTER_COPY_MOVE |-> !done ##1 done ##1 !busy)
    else $error("register copy move not two cycles");
  a_pm_load_eight: assert property (
    take && op == OP_PM_LOAD |-> !done [*7] ##1 done)
    else $error("program memory load not eight cycles");
  a_pm_store_strobe: assert property (
    take && op == OP_PM_STORE |-> ##7 pm_wr_en && pm_addr == $past(pm_addr))
    else $error("program memory store strobe misplaced");
  a_mode_bit_refuse: assert property (
    start && idle && is_pm && data_memory_execution_bit |-> illegal ##1 idle)
    else $error("program memory move taken in data-memory mode");
  a_tcc_skip_hold: assert property (
    take && op == OP_COND_TRANSFER && !cond_met |->
      ##2 acc_a == $past(acc_a, 2) && acc_b == $past(acc_b, 2))
    else $error("transfer changed accumulator with condition false");
  a_tcc_load_acc: assert property (
    take && op == OP_COND_TRANSFER && cond_met && src == REG_X0 &&
      dst == REG_ACCA |-> ##2 acc_a == $past(x0_acc_form, 2))
    else $error("transfer value into accumulator wrong");
  a_tcc_addr_copy: assert property (
    take && op == OP_COND_TRANSFER && cond_met && agu_copy |->
      ##2 addr_reg[1] == $past(addr_reg[0], 2))
    else $error("address copy missing");
  a_int_keep_low: assert property (
    take && op == OP_INTEGER_MULTIPLY && mdst == MDST_ACCA |->
      ##2 acc_a[15:0] == $past(acc_a[15:0], 2))
    else $error("integer multiply changed accumulator low word");
  a_mul_two_cycles: assert property (
    take && is_mul |-> ##1 done ##1 idle)
    else $error("multiply not two cycles");
  a_round_low_zero: assert property (
    take && (op == OP_ROUNDING_MAC || op == OP_ROUNDING_FRAC_MUL) &&
      mdst == MDST_ACCB |-> ##2 acc_b[15:0] == 16'h0000)
    else $error("rounded result has nonzero low word");

  c_pm_load: cover property (take && op == OP_PM_LOAD ##7 done);
  c_tcc_agu: cover property (take && op == OP_COND_TRANSFER && agu_copy &&
                             cond_met);
  c_mac_neg: cover property (take && op == OP_MULTIPLY_ACCUMULATE && negate);

endmodule : mme_exec
`default_nettype wire

// ### verilog/mme_pkg.sv
`default_nettype none
package mme_pkg;

  // Data path widths
  localparam int WORD_W = 16;
  localparam int ACC_W  = 36;

  // Cycle counts per instruction class
  localparam logic [3:0] CYC_MOVE = 4'h2;
  localparam logic [3:0] CYC_PMEM = 4'h8;
  localparam logic [3:0] CYC_TCC  = 4'h2;
  localparam logic [3:0] CYC_MUL  = 4'h2;

  // Reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [35:0] RST_ACC  = 36'h0_0000_0000;

  // Rounding constant and mask for the low word portion
  localparam logic [35:0] ROUND_ADD  = 36'h0_0000_8000;
  localparam logic [35:0] ROUND_MASK = 36'hF_FFFF_0000;

  // Instruction classes
  typedef enum logic [3:0] {
    OP_REGISTER_COPY_MOVE  = 4'h0,
    OP_PM_LOAD             = 4'h1,
    OP_PM_STORE            = 4'h2,
    OP_COND_TRANSFER       = 4'h3,
    OP_INTEGER_MULTIPLY    = 4'h4,
    OP_MULTIPLY_ACCUMULATE = 4'h5,
    OP_ROUNDING_MAC        = 4'h6,
    OP_FRACTIONAL_MULTIPLY = 4'h7,
    OP_ROUNDING_FRAC_MUL   = 4'h8
  } mme_op_t;

  // General register set
  typedef enum logic [3:0] {
    REG_X0        = 4'h0,
    REG_Y0        = 4'h1,
    REG_Y1        = 4'h2,
    REG_ACCA_LOW  = 4'h3,
    REG_ACCA_HIGH = 4'h4,
    REG_ACCA_EXT  = 4'h5,
    REG_ACCB_LOW  = 4'h6,
    REG_ACCB_HIGH = 4'h7,
    REG_ACCB_EXT  = 4'h8,
    REG_ACCA      = 4'h9,
    REG_ACCB      = 4'hA,
    REG_ADDR0     = 4'hB,
    REG_ADDR1     = 4'hC,
    REG_ADDR2     = 4'hD,
    REG_ADDR3     = 4'hE,
    REG_OFFSET    = 4'hF
  } mme_reg_t;

  // Multiply destination
  typedef enum logic [2:0] {
    MDST_ACCA = 3'h0,
    MDST_ACCB = 3'h1,
    MDST_X0   = 3'h2,
    MDST_Y0   = 3'h3,
    MDST_Y1   = 3'h4
  } mme_mdst_t;

  // Multiplier operand pairs
  typedef enum logic [2:0] {
    PAIR_Y1_X0 = 3'h0,
    PAIR_Y0_X0 = 3'h1,
    PAIR_Y1_Y0 = 3'h2,
    PAIR_Y0_Y0 = 3'h3,
    PAIR_A1_Y0 = 3'h4,
    PAIR_B1_Y1 = 3'h5
  } mme_pair_t;

  // Condition codes; the last four are refused by the transfer
  typedef enum logic [3:0] {
    COND_CARRY_CLEAR           = 4'h0,
    COND_CARRY_SET             = 4'h1,
    COND_NOT_EQUAL             = 4'h2,
    COND_EQUAL                 = 4'h3,
    COND_GREATER_EQUAL         = 4'h4,
    COND_LESS                  = 4'h5,
    COND_GREATER               = 4'h6,
    COND_LESS_EQUAL            = 4'h7,
    COND_UNSIGNED_GREATER      = 4'h8,
    COND_AT_MOST               = 4'h9,
    COND_NOT_NORMALIZED        = 4'hA,
    COND_NORMALIZED            = 4'hB
  } mme_cond_t;

  // Sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_PMEM = 2'b10
  } mme_state_t;

endpackage : mme_pkg
`default_nettype wire

// ### verilog/mme_mul_unit.sv
`default_nettype none
module mme_mul_unit
(
  input  wire logic [15:0] op_a,        // First multiplier operand
  input  wire logic [15:0] op_b,        // Second multiplier operand
  input  wire logic        negate,      // Negate the product
  input  wire logic        accumulate,  // Add product to acc_in
  input  wire logic        round_en,    // Round the result
  input  wire logic [35:0] acc_in,      // Accumulator addend
  output logic      [35:0] frac_result, // Fractional result
  output logic      [15:0] int_result   // Integer result
);
  import mme_pkg::*;

  logic signed [31:0] prod;      // Signed 16x16 product
  logic        [35:0] frac_raw;  // Product shifted to fractional form
  logic        [35:0] frac_sign; // Product after optional negation
  logic        [35:0] sum;       // After optional accumulation
  logic        [35:0] rounded;   // After rounding

  // Signed product
  assign prod       = $signed(op_a) * $signed(op_b);
  // Integer form keeps the low 16 bits
  assign int_result = prod[15:0];
  // Fractional form, sign-extended into 36 bits
  assign frac_raw   = {{3{prod[31]}}, prod, 1'b0};
  // Negating the product equals negating one operand
  assign frac_sign  = negate ? 36'(-frac_raw) : frac_raw;
  // Add into destination for the accumulate family
  assign sum        = accumulate ? 36'(acc_in + frac_sign) : frac_sign;
  // Round to the high word, clearing the low word
  assign rounded    = 36'(sum + ROUND_ADD) & ROUND_MASK;
  assign frac_result = round_en ? rounded : sum;

endmodule : mme_mul_unit
`default_nettype wire

// ### verification/mme_exec_tb_top.sv
`default_nettype none
module mme_exec_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import mme_pkg::*;

  // Stimulus and observed ports
  logic        clk;
  logic        reset_n;
  logic        start;
  logic        negate;
  logic        post_n;
  logic        cond_met;
  logic        agu_copy;
  logic        mode_bit;
  logic [1:0]  areg;
  mme_op_t     op;
  mme_reg_t    src;
  mme_reg_t    dst;
  mme_pair_t   pair;
  mme_mdst_t   mdst;
  mme_cond_t   cond_code;
  logic [15:0] pm_rdata;
  logic [15:0] pm_addr;
  logic [15:0] pm_wdata;
  logic [15:0] x0;
  logic [15:0] y0;
  logic [15:0] y1;
  logic [15:0] offset_n;
  logic [15:0] addr_reg [4];
  logic [35:0] acc_a;
  logic [35:0] acc_b;
  logic        pm_rd_en;
  logic        pm_wr_en;
  logic        busy;
  logic        done;
  logic        illegal;
  // Snapshot taken in the done cycle
  logic        wr_seen;
  logic        rd_seen;
  logic [15:0] addr_seen;
  logic [35:0] got;
  int          fails;
  int          n_compared;
  int          k;

  // One table row: inputs and the result they should leave
  typedef struct {
    mme_op_t o; mme_reg_t s; mme_reg_t d; mme_pair_t p; mme_mdst_t m;
    logic ng; logic met; int sel; logic [35:0] exp;
  } mme_row_t;
  mme_row_t rows [15];

  mme_exec u_mme_exec (
    .clk(clk), .reset_n(reset_n), .start(start), .op(op), .src(src),
    .dst(dst), .pair(pair), .mdst(mdst), .negate(negate), .areg(areg),
    .post_n(post_n), .cond_code(cond_code), .cond_met(cond_met),
    .agu_copy(agu_copy), .data_memory_execution_bit(mode_bit),
    .pm_rdata(pm_rdata), .pm_addr(pm_addr), .pm_wdata(pm_wdata),
    .pm_rd_en(pm_rd_en), .pm_wr_en(pm_wr_en), .busy(busy), .done(done),
    .illegal(illegal), .x0(x0), .y0(y0), .y1(y1), .acc_a(acc_a),
    .acc_b(acc_b), .addr_reg(addr_reg), .offset_n(offset_n)
  );

  // Free-running 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Four-state compare, counted
  task automatic chk(input string what, input logic [35:0] exp, got);
    n_compared++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Counts and verdict
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  // Issue one instruction at a falling edge; poke repeats start while busy
  task automatic issue(input mme_op_t o, input mme_reg_t s, d,
    input mme_pair_t p, input mme_mdst_t m, input logic ng, poke,
    input int n);
    op = o; src = s; dst = d; pair = p; mdst = m; negate = ng;
    start = 1'b1;
    @(negedge clk);
    start = poke;
    k = 1;
    while (done !== 1'b1 && k < 20)
    begin
      @(negedge clk);
      start = 1'b0;
      k++;
    end
    wr_seen = pm_wr_en; rd_seen = pm_rd_en; addr_seen = pm_addr;
    chk("cycles", 36'(n), 36'(k + 1));
    if (k >= 20)
    begin
      fails++;
      end_sim();
    end
    @(negedge clk);
  endtask : issue

  // Program memory load; the read bus shows junk outside the load
  task automatic load(input logic [15:0] rd, input mme_reg_t d,
    input logic [1:0] a, input logic pn, poke, input logic [15:0] ea);
    pm_rdata = rd; areg = a; post_n = pn;
    issue(OP_PM_LOAD, REG_X0, d, PAIR_Y1_X0, MDST_ACCA, 1'b0, poke, 8);
    pm_rdata = ~rd;
    @(negedge clk);
    chk("pm_addr", 36'(ea), 36'(addr_seen));
    chk("pm_rd_en", 36'h1, 36'(rd_seen));
  endtask : load

  // Start that must be refused in its own cycle
  task automatic refuse(input mme_op_t o, input mme_cond_t c,
    input mme_pair_t p);
    op = o; cond_code = c; pair = p; src = REG_X0; dst = REG_ACCB;
    mdst = MDST_ACCA; start = 1'b1;
    #1;
    chk("illegal", 36'h1, 36'(illegal));
    @(negedge clk);
    start = 1'b0;
    chk("busy", 36'h0, 36'(busy));
    @(negedge clk);
  endtask : refuse

  // Main sequence
  initial
  begin
    rows = '{
      '{OP_FRACTIONAL_MULTIPLY, REG_X0, REG_X0, PAIR_Y1_X0, MDST_ACCA,
        0, 1, 0, 36'hF_E000_0000},
      '{OP_FRACTIONAL_MULTIPLY, REG_X0, REG_X0, PAIR_Y0_X0, MDST_ACCB,
        1, 1, 1, 36'hF_FFFE_8000},
      '{OP_MULTIPLY_ACCUMULATE, REG_X0, REG_X0, PAIR_Y0_Y0, MDST_ACCA,
        0, 1, 0, 36'hF_E000_0012},
      '{OP_MULTIPLY_ACCUMULATE, REG_X0, REG_X0, PAIR_Y0_X0, MDST_ACCA,
        1, 1, 0, 36'hF_DFFE_8012},
      '{OP_INTEGER_MULTIPLY, REG_X0, REG_X0, PAIR_Y1_Y0, MDST_ACCA,
        0, 1, 0, 36'h0_4000_8012},
      '{OP_ROUNDING_MAC, REG_X0, REG_X0, PAIR_Y0_Y0, MDST_ACCA,
        0, 1, 0, 36'h0_4001_0000},
      '{OP_ROUNDING_FRAC_MUL, REG_X0, REG_X0, PAIR_Y0_X0, MDST_ACCB,
        0, 1, 1, 36'h0_0002_0000},
      '{OP_ROUNDING_FRAC_MUL, REG_X0, REG_X0, PAIR_Y0_X0, MDST_ACCB,
        1, 1, 1, 36'hF_FFFF_0000},
      '{OP_INTEGER_MULTIPLY, REG_X0, REG_X0, PAIR_A1_Y0, MDST_Y1,
        0, 1, 3, 36'h0_0000_C003},
      '{OP_REGISTER_COPY_MOVE, REG_ACCA_HIGH, REG_X0, PAIR_Y1_X0,
        MDST_ACCA, 0, 1, 2, 36'h0_0000_4001},
      '{OP_COND_TRANSFER, REG_Y1, REG_ACCB, PAIR_Y1_X0, MDST_ACCA,
        0, 1, 1, 36'hF_C003_0000},
      '{OP_COND_TRANSFER, REG_X0, REG_ACCA, PAIR_Y1_X0, MDST_ACCA,
        0, 0, 0, 36'h0_4001_0000},
      '{OP_COND_TRANSFER, REG_ACCA, REG_ACCB, PAIR_Y1_X0, MDST_ACCA,
        0, 1, 1, 36'h0_4001_0000},
      '{OP_INTEGER_MULTIPLY, REG_X0, REG_X0, PAIR_B1_Y1, MDST_X0,
        0, 1, 2, 36'h0_0000_8003},
      '{OP_COND_TRANSFER, REG_X0, REG_ACCA, PAIR_Y1_X0, MDST_ACCA,
        0, 1, 0, 36'hF_8003_0000}};
    reset_n = 1'b0; start = 1'b0; op = OP_REGISTER_COPY_MOVE;
    src = REG_X0; dst = REG_X0; pair = PAIR_Y1_X0; mdst = MDST_ACCA;
    negate = 1'b0; areg = 2'h0; post_n = 1'b0; cond_code = COND_EQUAL;
    cond_met = 1'b1; agu_copy = 1'b1; mode_bit = 1'b0;
    pm_rdata = 16'h0000; fails = 0; n_compared = 0;
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    chk("acc_a reset", 36'h0, acc_a);
    chk("busy reset", 36'h0, 36'(busy));
    // Operand setup through loads; third one pokes start while busy
    load(16'h4000, REG_X0, 2'h0, 1'b0, 1'b0, 16'h0000);
    load(16'h0005, REG_OFFSET, 2'h0, 1'b0, 1'b0, 16'h0001);
    load(16'h0003, REG_Y0, 2'h0, 1'b1, 1'b1, 16'h0002);
    load(16'hC000, REG_Y1, 2'h2, 1'b0, 1'b0, 16'h0000);
    chk("x0", 36'h4000, 36'(x0));
    chk("y0", 36'h0003, 36'(y0));
    chk("y1", 36'hC000, 36'(y1));
    chk("offset_n", 36'h0005, 36'(offset_n));
    chk("addr_reg2", 36'h0001, 36'(addr_reg[2]));
    chk("addr_reg0", 36'h0007, 36'(addr_reg[0]));
    // Store of Y1 at the stepped address
    areg = 2'h0;
    issue(OP_PM_STORE, REG_Y1, REG_X0, PAIR_Y1_X0, MDST_ACCA, 1'b0,
      1'b0, 8);
    chk("store addr", 36'h0007, 36'(addr_seen));
    chk("pm_wdata", 36'hC000, 36'(pm_wdata));
    chk("pm_wr_en", 36'h1, 36'(wr_seen));
    chk("pm_wr_en after", 36'h0, 36'(pm_wr_en));
    chk("addr_reg0", 36'h0008, 36'(addr_reg[0]));
    // Refusals: mode bit, barred conditions, pair out of range
    mode_bit = 1'b1;
    refuse(OP_PM_LOAD, COND_EQUAL, PAIR_Y1_X0);
    mode_bit = 1'b0;
    chk("addr_reg0 kept", 36'h0008, 36'(addr_reg[0]));
    for (int c = 8; c < 12; c++)
      refuse(OP_COND_TRANSFER, mme_cond_t'(c), PAIR_Y1_X0);
    refuse(OP_FRACTIONAL_MULTIPLY, COND_EQUAL, mme_pair_t'(3'h6));
    cond_code = COND_EQUAL;
    // Table of datapath cases, run back to back
    foreach (rows[i])
    begin
      cond_met = rows[i].met;
      issue(rows[i].o, rows[i].s, rows[i].d, rows[i].p, rows[i].m,
        rows[i].ng, 1'b0, 2);
      got = (rows[i].sel == 0) ? acc_a : (rows[i].sel == 1) ? acc_b :
        (rows[i].sel == 2) ? 36'(x0) : 36'(y1);
      chk($sformatf("row %0d", i), rows[i].exp, got);
    end
    chk("addr_reg1", 36'h0008, 36'(addr_reg[1]));
    // Second reset in mid-run
    reset_n = 1'b0;
    @(negedge clk);
    reset_n = 1'b1;
    chk("acc_b reset", 36'h0, acc_b);
    chk("addr_reg0 reset", 36'h0, 36'(addr_reg[0]));
    end_sim();
  end
endmodule : mme_exec_tb_top
`default_nettype wire
